// File: fbm_params.svh
// Constants for the flash bus mode host controller.
// Assumes a 50 MHz CLOCK; times in ns are converted to cycle counts here.
`ifndef FBM_PARAMS_SVH
`define FBM_PARAMS_SVH
`define FBM_CLK_PERIOD_NS 20
`define FBM_ACC_NS 70
`define FBM_CE_NS 70
`define FBM_SLEEP_EXTRA_NS 30
`define FBM_RP_NS 500
`define FBM_RH_NS 50
`define FBM_READY_NS 20000
`define FBM_ACC_CYC ((`FBM_ACC_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_CE_CYC ((`FBM_CE_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_SLEEP_CYC \
  ((`FBM_ACC_NS + `FBM_SLEEP_EXTRA_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_RP_CYC ((`FBM_RP_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_RH_CYC ((`FBM_RH_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_READY_CYC ((`FBM_READY_NS + `FBM_CLK_PERIOD_NS - 1) / `FBM_CLK_PERIOD_NS)
`define FBM_SECT_HI 19
`define FBM_SECT_LO 12
`define FBM_BIG_LSB 15
`define FBM_TOP_BIG 5'h1f
`define FBM_SECT_TOP_BASE 6'h1f
`define FBM_CNT_W 16
`endif

// File: fbm_pkg.sv
// Types for the flash bus mode host controller.
// Constants live in fbm_params.svh.
package fbm_pkg;
  typedef enum logic [2:0] {
    FBM_IDLE = 3'b000,
    FBM_RSTP = 3'b001,
    FBM_RSTR = 3'b011,
    FBM_RD = 3'b010,
    FBM_WR = 3'b110,
    FBM_REC = 3'b111
  } fbm_state_e;
endpackage

// File: fbm_host.sv
// Host controller driving a parallel NOR flash through its bus pins.
// Assumes the flash pins are sampled synchronously to CLOCK.
// Summary of operation
// - Host holds clear low at least the minimum clear pulse width.
// - Host flags an interrupted program or erase on RESTART_NEEDED after clear.
// - Host keeps chip-select high until clear has returned high.
// - Host reads no earlier than the recovery delay after clear rises.
`timescale 1ns/1ns
`include "fbm_params.svh"
module fbm_host #(
  parameter int ADDR_W = 20,
  parameter int READY_CYC = `FBM_READY_CYC
) (
  // System
  input wire logic CLOCK,
  input wire logic RST,
  // User request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_CLEAR,
  input wire logic BYTE_MODE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RESP_VALID,
  output logic [15:0] RESP_RDATA,
  output logic [5:0] RESP_SECTOR,
  output logic RESTART_NEEDED,
  // Flash pins
  output logic [ADDR_W-1:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RESET_N,
  output logic FL_BYTE_N,
  input wire logic [15:0] FL_DQ_I,
  output logic [15:0] FL_DQ_O,
  output logic [15:0] FL_DQ_OE,
  input wire logic FL_READY_BUSY_N
);
  fbm_pkg::fbm_state_e state_reg, state_next;
  logic [`FBM_CNT_W-1:0] cnt_reg, cnt_next;
  logic [15:0] rdata_reg;
  logic [5:0] sect_reg;
  logic resp_reg, restart_reg, byte_reg, data_drive_reg;
  logic data_lsb_reg;
  logic [`FBM_CNT_W-1:0] low_cnt_reg;

  // Sector decode from A19..A12, same bits in both widths
  function automatic logic [5:0] fbm_sector(input logic [7:0] hi);
    if (hi[7:3] != `FBM_TOP_BIG)
      return {1'b0, hi[7:3]};
    else if (!hi[2])
      return `FBM_SECT_TOP_BASE;
    else if (!hi[1])
      return 6'(`FBM_SECT_TOP_BASE + 6'h01 + 6'(hi[0]));
    else
      return 6'(`FBM_SECT_TOP_BASE + 6'h03);
  endfunction

  wire logic [7:0] sect_bits = REQ_ADDR[`FBM_SECT_HI:`FBM_SECT_LO];
  wire logic idle_w = (state_reg == fbm_pkg::FBM_IDLE);
  wire logic busy_w = !FL_READY_BUSY_N;
  wire logic cnt_done = (cnt_reg == '0);
  wire logic take_w = idle_w && REQ_VALID;
  wire logic [15:0] rd_mux = byte_reg ? {8'h00, FL_DQ_I[7:0]} : FL_DQ_I;

  assign REQ_READY = idle_w;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_done ? cnt_reg : `FBM_CNT_W'(cnt_reg - 1'b1);
    unique case (state_reg)
      fbm_pkg::FBM_IDLE:
        if (REQ_VALID && REQ_CLEAR)
        begin
          state_next = fbm_pkg::FBM_RSTP;
          cnt_next = `FBM_CNT_W'(`FBM_RP_CYC - 1);
        end
        else if (REQ_VALID)
        begin
          state_next = REQ_WRITE ? fbm_pkg::FBM_WR : fbm_pkg::FBM_RD;
          cnt_next = `FBM_CNT_W'(`FBM_CE_CYC - 1);
        end
      fbm_pkg::FBM_RSTP:
        if (cnt_done)
        begin
          state_next = fbm_pkg::FBM_RSTR;
          cnt_next = `FBM_CNT_W'(READY_CYC - 1);
        end
      fbm_pkg::FBM_RSTR:
        if (FL_READY_BUSY_N || cnt_done)
        begin
          state_next = fbm_pkg::FBM_REC;
          cnt_next = `FBM_CNT_W'(`FBM_RH_CYC - 1);
        end
      fbm_pkg::FBM_RD, fbm_pkg::FBM_WR:
        if (cnt_done)
          state_next = fbm_pkg::FBM_IDLE;
      fbm_pkg::FBM_REC:
        if (cnt_done)
          state_next = fbm_pkg::FBM_IDLE;
      default:
        state_next = fbm_pkg::FBM_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= fbm_pkg::FBM_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Pin drive: chip-select only while a read or write cycle runs
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      FL_CE_N <= 1'b1;
      FL_OE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_RESET_N <= 1'b1;
      FL_ADDR <= '0;
      FL_BYTE_N <= 1'b1;
      FL_DQ_O <= '0;
    end
    else
    begin
      // Clear held low, chip-select forced high meanwhile
      FL_RESET_N <= !(state_next == fbm_pkg::FBM_RSTP);
      FL_CE_N <= !(state_next == fbm_pkg::FBM_RD || state_next == fbm_pkg::FBM_WR);
      FL_OE_N <= !(state_next == fbm_pkg::FBM_RD);
      FL_WE_N <= !(state_next == fbm_pkg::FBM_WR);
      if (take_w && !REQ_CLEAR)
      begin
        FL_ADDR <= REQ_ADDR;
        FL_BYTE_N <= !BYTE_MODE;
        FL_DQ_O <= REQ_WDATA;
        // Byte mode: data 15 carries the low address bit
        if (BYTE_MODE)
          FL_DQ_O[15] <= REQ_WDATA[15];
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      data_drive_reg <= 1'b0;
      byte_reg <= 1'b0;
      data_lsb_reg <= 1'b0;
    end
    else
    begin
      data_drive_reg <= (state_next == fbm_pkg::FBM_WR);
      if (take_w && !REQ_CLEAR)
      begin
        byte_reg <= BYTE_MODE;
        data_lsb_reg <= BYTE_MODE;
      end
    end
  end

  // Bus released except on writes; data 15 kept driven as address in byte mode
  assign FL_DQ_OE = data_drive_reg ? (byte_reg ? 16'h80ff : 16'hffff)
                                   : (data_lsb_reg ? 16'h8000 : 16'h0000);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      resp_reg <= 1'b0;
      rdata_reg <= '0;
      sect_reg <= '0;
      restart_reg <= 1'b0;
    end
    else
    begin
      resp_reg <= (state_reg != fbm_pkg::FBM_IDLE) && (state_next == fbm_pkg::FBM_IDLE);
      if (state_reg == fbm_pkg::FBM_RD && cnt_done)
        rdata_reg <= rd_mux;
      if (take_w)
        sect_reg <= fbm_sector(sect_bits);
      // Busy at clear time means an interrupted program or erase
      if (state_reg == fbm_pkg::FBM_IDLE && REQ_VALID && REQ_CLEAR)
        restart_reg <= busy_w;
      else if (take_w)
        restart_reg <= 1'b0;
    end
  end

  assign RESP_VALID = resp_reg;
  assign RESP_RDATA = rdata_reg;
  assign RESP_SECTOR = sect_reg;
  assign RESTART_NEEDED = restart_reg;

  // Length of the clear pulse so far; only the a_clear_full check reads it
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      low_cnt_reg <= '0;
    else
      low_cnt_reg <= FL_RESET_N ? '0 : `FBM_CNT_W'(low_cnt_reg + 1'b1);
  end

  a_ce_after_clear: assert property (@(posedge CLOCK) disable iff (RST)
    !FL_RESET_N |-> FL_CE_N)
    else $error("chip select active while clear held");
  a_clear_width: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(FL_RESET_N) |-> !FL_RESET_N [*8])
    else $error("clear pulse too short");
  a_clear_full: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(FL_RESET_N) |-> (low_cnt_reg >= `FBM_CNT_W'(`FBM_RP_CYC)))
    else $error("clear pulse shorter than minimum");
  a_read_wait: assert property (@(posedge CLOCK) disable iff (RST)
    $fell(FL_OE_N) |-> !FL_OE_N [*4])
    else $error("read strobe too short");
  a_recover_gap: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(FL_RESET_N) |-> FL_CE_N [*3])
    else $error("access too soon after clear");
  a_bus_release: assert property (@(posedge CLOCK) disable iff (RST)
    !FL_OE_N |-> (FL_DQ_OE[14:0] == 15'h0000))
    else $error("host drives data during read");
  a_no_collide: assert property (@(posedge CLOCK) disable iff (RST)
    !(!FL_OE_N && !FL_WE_N))
    else $error("read and write strobes together");
  a_ready_bound: assert property (@(posedge CLOCK) disable iff (RST)
    (state_reg == fbm_pkg::FBM_RSTR) |-> ##[0:1000] (state_reg != fbm_pkg::FBM_RSTR)
      or (cnt_reg > `FBM_CNT_W'(1000)))
    else $error("clear recovery overran");
  a_sector_top: assert property (@(posedge CLOCK) disable iff (RST)
    (take_w && sect_bits == 8'hff) |=> (RESP_SECTOR == 6'h22))
    else $error("top sector decode wrong");
endmodule

// File: fbm_flash_model.sv
// Flash device model for the host bench.
// Pins change just after clock edges.
`timescale 1ns/1ns
module fbm_flash_model (
  // Bus controls
  input wire logic clock,
  input wire logic [19:0] fl_addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic byte_n,
  // Data and status
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_drv,
  output logic rb_n
);
  logic [15:0] last_reg = 16'h0, word;
  logic drive;
  int busy_reg = 0;
  assign drive = !ce_n && !oe_n && we_n && rst_n;
  assign word = fl_addr[15:0] ^ 16'h5a3c;
  // Floating lines flip, never hold old data
  assign dq_drv = !drive ? ~last_reg : byte_n ? word :
    {~last_reg[15:8], dq_i[15] ? word[15:8] : word[7:0]};
  assign rb_n = busy_reg == 0;
  always @(posedge clock)
  begin
    if (drive)
      last_reg <= dq_drv;
    if (!rst_n && busy_reg > 0)
      busy_reg <= 8;
    else if (rst_n && !ce_n && !we_n && busy_reg == 0)
      busy_reg <= 10;
    else if (busy_reg > 0)
      busy_reg <= busy_reg - 1;
  end
endmodule

// File: test_flash_bus_mode_control.sv
// Bench for the flash bus mode host controller.
// The flash model answers on the far side.
`timescale 1ns/1ns
`include "fbm_params.svh"
module test_flash_bus_mode_control;
  typedef struct packed {logic bm; logic [19:0] a; logic lsb; logic [5:0] s;} fbm_row_s;
  localparam fbm_row_s ROWS [8] = '{{1'h0, 20'h0, 1'h0, 6'h0},
    {1'h0, 20'h7ffff, 1'h0, 6'hf}, {1'h1, 20'hd8123, 1'h1, 6'h1b},
    {1'h0, 20'hf0000, 1'h0, 6'h1e}, {1'h0, 20'hf8000, 1'h0, 6'h1f},
    {1'h1, 20'hfc000, 1'h0, 6'h20}, {1'h0, 20'hfd000, 1'h0, 6'h21},
    {1'h0, 20'hfe000, 1'h0, 6'h22}};
  logic clock = 1'h0, rst = 1'h1, valid = 1'h0, bm = 1'h0;
  logic [1:0] op = 2'h0;
  logic [19:0] addr = 20'h0, fl_addr;
  logic [15:0] wdata = 16'h0, rdata, dq_o, dq_oe, dq_drv, dq_i, w, e;
  logic [5:0] sect;
  logic ready, resp, restart, ce_n, oe_n, we_n, rst_n, byte_n, rb_n;
  int num_errors = 0, compares = 0, lo = 0, hi = 99;
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & dq_drv);
  initial forever #10 clock = ~clock;
  fbm_host #(.READY_CYC(20)) dut (.CLOCK(clock), .RST(rst), .REQ_VALID(valid),
    .REQ_WRITE(op[1]), .REQ_CLEAR(op[0]), .BYTE_MODE(bm), .REQ_ADDR(addr), .REQ_WDATA(wdata),
    .REQ_READY(ready), .RESP_VALID(resp), .RESP_RDATA(rdata), .RESP_SECTOR(sect),
    .RESTART_NEEDED(restart), .FL_ADDR(fl_addr), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
    .FL_WE_N(we_n), .FL_RESET_N(rst_n), .FL_BYTE_N(byte_n), .FL_DQ_I(dq_i), .FL_DQ_O(dq_o),
    .FL_DQ_OE(dq_oe), .FL_READY_BUSY_N(rb_n));
  fbm_flash_model flash (.clock, .fl_addr, .ce_n, .oe_n, .we_n, .rst_n, .byte_n, .dq_i,
    .dq_drv, .rb_n);
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (!ok)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic idle();
    chk({ce_n, oe_n, we_n, rst_n, dq_oe, resp} === {4'hf, 16'h0, 1'h0}, "idle pins");
  endtask
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic req(input logic [2:0] k, input logic [19:0] a, input logic [15:0] d);
    int n;
    for (n = 0; ready !== 1'h1 && n < 200; n++) @(negedge clock);
    {valid, op, bm, addr, wdata} = {1'h1, k, a, d};
    @(negedge clock);
    valid = 1'h0;
    for (; resp !== 1'h1 && n < 200; n++) @(negedge clock);
    chk(n < 200, "no response");
  endtask
  initial
  begin
    repeat (12) @(negedge clock);
    idle();
    rst = 1'h0;
    foreach (ROWS[i])
    begin
      req({2'h0, ROWS[i].bm}, ROWS[i].a, {ROWS[i].lsb, 15'h0});
      w = ROWS[i].a[15:0] ^ 16'h5a3c;
      e = ROWS[i].bm ? {8'h0, ROWS[i].lsb ? w[15:8] : w[7:0]} : w;
      chk(rdata === e && sect === ROWS[i].s, "read row");
      $display("read row %0d done", i);
    end
    req(3'h4, 20'h12345, 16'hbeef);
    chk(rb_n === 1'h0, "program not busy");
    req(3'h2, 20'h0, 16'h0);
    chk(restart === 1'h1 && rb_n === 1'h1, "clear in program");
    req(3'h2, 20'h0, 16'h0);
    chk(restart === 1'h0, "clear when idle");
    req(3'h0, 20'hfe000, 16'h0);
    chk(rdata === 16'hba3c, "read after clear");
    $display("clear tests done");
    rst = 1'h1;
    @(negedge clock);
    idle();
    rst = 1'h0;
    req(3'h1, ROWS[2].a, 16'h8000);
    chk(rdata === 16'h00db && sect === ROWS[2].s, "read after reset");
    $display("second reset done");
    summarize();
  end
  initial
  begin
    repeat (2000) @(posedge clock);
    chk(1'h0, "timeout");
    summarize();
  end
  always @(negedge clock)
  begin
    if (rst_n === 1'h0)
      chk(ce_n === 1'h1, "select in clear");
    else if (lo > 0)
      chk(lo >= `FBM_RP_CYC, "short clear");
    if (ce_n === 1'h0)
      chk(hi >= `FBM_RH_CYC, "early read");
    if (we_n === 1'h0)
      chk({oe_n, dq_oe, dq_i, fl_addr} === {1'h1, 16'hffff, 16'hbeef, 20'h12345},
        "write bus");
    lo <= rst_n === 1'h0 ? lo + 1 : 0;
    hi <= rst_n === 1'h0 ? 0 : hi + 1;
  end
endmodule
